//--- logic/diff_clock_map.svh
// constants of the differential clock output control block
// assumes a 250 MHz core clock; included by the diff_clock_output_control module only
`ifndef DIFF_CLOCK_MAP_SVH
`define DIFF_CLOCK_MAP_SVH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS 4000
`define NUM_PAIRS 4

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_CTRL0 8'h00
`define ADDR_CTRL1 8'h01
`define ADDR_CTRL2 8'h02
`define ADDR_VENDOR 8'h04
`define ADDR_STATUS 8'h06

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define CTRL0_RST 8'h07
`define CTRL1_RST 8'hff
`define CTRL2_RST 8'h00
`define CTRL0_MASK 8'hc7
`define PAIR_MASK 8'h66
// arbitrary vendor and revision value
`define VENDOR_ID 8'h5a

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define B_PD_TRI 7
`define B_STOP_TRI 6
`define B_BW 2
`define B_BYP 1
`define B_HALF 0
`define PAIR_BIT(i) ((i) == 0 ? 1 : (i) == 1 ? 2 : (i) == 2 ? 5 : 6)

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PWRUP_DLY_NS 200000
`define PWRUP_DLY_CYC ((`PWRUP_DLY_NS * 1000 + `CLK_PERIOD_PS - 1) / \
  `CLK_PERIOD_PS)
`define LOCK_MAX_NS 1000000
`define LOCK_MAX_CYC ((`LOCK_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define DRIVE_HI_NS 10
`define DRIVE_HI_CYC ((`DRIVE_HI_NS * 1000) / `CLK_PERIOD_PS)

`endif

//--- logic/diff_clock_output_control.sv
// control logic of a four-pair differential clock fan-out buffer
// assumes all pins are asynchronous to core_clk and the reference clock
// is slow enough to be sampled at the core rate
//
// Function
// - power-down pin is synchronised; low on two comp rising edges asserts
// - after power-down, park all true outputs on next comp falling edge
// - parked: drive mode 0 holds true high at 2x, comp floats; 1 floats
// - stable clocks with lock under 1 ms after release, supply or clock
// - three-state mode: true outputs driven high soon after release
// - sequencer starts off, then waits 0.2 to 0.3 ms after supply
// - then waits for valid reference and release; no clock means disabled
// - outputs enabled only after the pll reports lock
// - stop pin debounced: level must hold over two comp rising edges
// - stop halts only stoppable outputs after their next transition
// - stopped: mode 0 true high at 6x, comp floats; mode 1 both float
// - stop release restarts stopped outputs together and glitch-free
// - three-state stop mode: true driven high within 10 ns of release
// - pair floats if register enable or enable pin is low
// - enabled pair resumes glitch-free; true high within 10 ns
// - disabled pair goes to three-state glitch-free
// - half-rate bit 0 halves output clock; 1 restores, glitch-free
// - bypass if bypass bit or bypass pin is low
// - low bandwidth if bandwidth bit or bandwidth pin is low
// - control byte 0: drive modes, bandwidth, bypass, half-rate
// - control byte 1: per-pair enables, reset to 1
// - control byte 2: per-pair stop enables, reset to 0
`default_nettype none
`include "diff_clock_map.svh"

module diff_clock_output_control
  import diff_clock_pkg::*;
#(
  parameter int DLY_CYC = `PWRUP_DLY_CYC,
  parameter int LOCK_CYC = `LOCK_MAX_CYC
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // asynchronous control pins
  input wire logic power_down_n,
  input wire logic output_stop_n,
  input wire logic [3:0] oe_pin,
  input wire logic bypass_select_n,
  input wire logic bandwidth_select_n,
  input wire logic supply_ok,
  input wire logic ref_clock_valid,
  input wire logic ref_clock_in,
  // pll
  input wire logic pll_locked,
  output logic pll_enable,
  output logic pll_bypass,
  output logic pll_low_bw,
  // output pairs
  output pair_drive_s diff_out [`NUM_PAIRS]
);

  localparam logic [17:0] DLY_LAST = 18'(DLY_CYC - 1);
  localparam logic [17:0] LOCK_LAST = 18'(LOCK_CYC - 1);
  // synchronisers rest at the pins' idle levels: no false edge after reset
  localparam pins_s PINS_IDLE = '{power_down_n: 1'b1, output_stop_n: 1'b1,
    oe_pin: 4'h0, bypass_select_n: 1'b1, bandwidth_select_n: 1'b1,
    supply_ok: 1'b0, ref_valid: 1'b0, ref_clock_in: 1'b0, pll_locked: 1'b0};

  pins_s pins, s1_q, s2_q;
  logic ref_q, ref_d, div_q, div_d, half_q, half_d, src_last_q;
  logic src, src_rise, src_fall;
  logic [1:0] pd_cnt_q, pd_cnt_d;
  logic pd_rec_q, pd_rec_d, stop_cand_q, stop_cand_d;
  logic stop_rec_q, stop_rec_d;
  seq_state_e seq_q, seq_d;
  logic [17:0] cnt_q, cnt_d;
  logic lock_late_q, lock_late_d, pd_seen_q, pd_seen_d;
  logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
  logic [7:0] rdata_q, rdata_d;
  logic byp_q, byp_d, lowbw_q, lowbw_d;
  logic [3:0] en_eff, stop_en;
  gate_ctrl_s gctl;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  always_comb begin
    pins = '{power_down_n, output_stop_n, oe_pin, bypass_select_n,
      bandwidth_select_n, supply_ok, ref_clock_valid, ref_clock_in,
      pll_locked};
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= PINS_IDLE;
      s2_q <= PINS_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // output clock source and half-rate switch
  // ----------------------------------------------------------------------
  always_comb begin
    ref_d = s2_q.ref_clock_in;
    div_d = div_q;
    half_d = half_q;
    if (ref_d && !ref_q) begin
      div_d = ~div_q;
      // switch only where both candidates rise together
      if (!div_q) begin
        half_d = ~ctrl0_q[`B_HALF];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= 1'b0;
      div_q <= 1'b0;
      half_q <= 1'b0;
      src_last_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      div_q <= div_d;
      half_q <= half_d;
      src_last_q <= src;
    end
  end

  // comp rising edge is a true falling edge
  assign src = half_q ? div_q : ref_q;
  assign src_rise = src & ~src_last_q;
  assign src_fall = ~src & src_last_q;

  // ----------------------------------------------------------------------
  // power-down and stop recognition
  // ----------------------------------------------------------------------
  always_comb begin
    pd_cnt_d = pd_cnt_q;
    pd_rec_d = pd_rec_q;
    stop_cand_d = stop_cand_q;
    stop_rec_d = stop_rec_q;
    if (s2_q.power_down_n) begin
      // release is taken at once: it must also wake a stopped clock
      pd_cnt_d = 2'h0;
      pd_rec_d = 1'b0;
    end else if (src_fall) begin
      if (pd_cnt_q == 2'h1) begin
        pd_rec_d = 1'b1;
      end
      if (pd_cnt_q != 2'h2) begin
        pd_cnt_d = pd_cnt_q + 2'h1;
      end
    end
    if (src_fall) begin
      stop_cand_d = s2_q.output_stop_n;
      if (s2_q.output_stop_n == stop_cand_q) begin
        stop_rec_d = ~s2_q.output_stop_n;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_cnt_q <= 2'h0;
      pd_rec_q <= 1'b0;
      stop_cand_q <= 1'b1;
      stop_rec_q <= 1'b0;
    end else begin
      pd_cnt_q <= pd_cnt_d;
      pd_rec_q <= pd_rec_d;
      stop_cand_q <= stop_cand_d;
      stop_rec_q <= stop_rec_d;
    end
  end

  // ----------------------------------------------------------------------
  // power-up sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    lock_late_d = lock_late_q;
    pd_seen_d = pd_seen_q;
    if (reg_wr && reg_addr == `ADDR_STATUS) begin
      lock_late_d = 1'b0;
    end
    if (!s2_q.supply_ok) begin
      seq_d = SEQ_OFF;
      cnt_d = '0;
      pd_seen_d = 1'b0;
    end else begin
      unique case (seq_q)
        SEQ_OFF: begin
          seq_d = SEQ_DELAY;
          cnt_d = '0;
        end
        SEQ_DELAY: begin
          cnt_d = cnt_q + 18'h1;
          if (cnt_q == DLY_LAST) begin
            seq_d = SEQ_WAIT;
            cnt_d = '0;
          end
        end
        SEQ_WAIT: begin
          if (s2_q.ref_valid && s2_q.power_down_n && !pd_rec_q) begin
            if (cnt_q != LOCK_LAST) begin
              cnt_d = cnt_q + 18'h1;
            end else begin
              lock_late_d = 1'b1;
            end
            if (s2_q.pll_locked) begin
              seq_d = SEQ_RUN;
              pd_seen_d = 1'b0;
            end
          end else begin
            cnt_d = '0;
          end
        end
        SEQ_RUN: begin
          if (pd_rec_q && src_rise) begin
            seq_d = SEQ_PARKED;
            pd_seen_d = 1'b1;
          end
        end
        SEQ_PARKED: begin
          if (s2_q.power_down_n) begin
            seq_d = SEQ_WAIT;
            cnt_d = '0;
          end
        end
        default: begin
          seq_d = SEQ_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= SEQ_OFF;
      cnt_q <= '0;
      lock_late_q <= 1'b0;
      pd_seen_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      lock_late_q <= lock_late_d;
      pd_seen_q <= pd_seen_d;
    end
  end

  assign pll_enable = (seq_q == SEQ_WAIT) || (seq_q == SEQ_RUN);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_CTRL0: ctrl0_d = reg_wdata & `CTRL0_MASK;
        `ADDR_CTRL1: ctrl1_d = reg_wdata | ~`PAIR_MASK;
        `ADDR_CTRL2: ctrl2_d = reg_wdata & `PAIR_MASK;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_CTRL0: rdata_d = ctrl0_q;
        `ADDR_CTRL1: rdata_d = ctrl1_q;
        `ADDR_CTRL2: rdata_d = ctrl2_q;
        `ADDR_VENDOR: rdata_d = `VENDOR_ID;
        `ADDR_STATUS: rdata_d = {seq_q, lock_late_q, pd_rec_q, stop_rec_q};
        default: rdata_d = 8'h00;
      endcase
    end
    byp_d = ~ctrl0_q[`B_BYP] | ~s2_q.bypass_select_n;
    lowbw_d = ~ctrl0_q[`B_BW] | ~s2_q.bandwidth_select_n;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_q <= `CTRL0_RST;
      ctrl1_q <= `CTRL1_RST;
      ctrl2_q <= `CTRL2_RST;
      rdata_q <= 8'h00;
      byp_q <= 1'b0;
      lowbw_q <= 1'b0;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      rdata_q <= rdata_d;
      byp_q <= byp_d;
      lowbw_q <= lowbw_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pll_bypass = byp_q;
  assign pll_low_bw = lowbw_q;

  // ----------------------------------------------------------------------
  // pair gates
  // ----------------------------------------------------------------------
  always_comb begin
    gctl.park = (seq_q != SEQ_RUN);
    // after a release the pairs stay high until lock; before, they float
    gctl.park_float = (seq_q == SEQ_PARKED) ? ctrl0_q[`B_PD_TRI] :
      !(seq_q == SEQ_WAIT && pd_seen_q && s2_q.ref_valid);
    gctl.stop = stop_rec_q;
    gctl.stop_live = s2_q.output_stop_n;
    gctl.stop_tri = ctrl0_q[`B_STOP_TRI];
  end

  for (genvar g = 0; g < `NUM_PAIRS; g++) begin : g_pair
    assign en_eff[g] = ctrl1_q[`PAIR_BIT(g)] & s2_q.oe_pin[g];
    assign stop_en[g] = ctrl2_q[`PAIR_BIT(g)];

    diff_pair_gate u_gate (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .src(src),
      .src_rise(src_rise),
      .src_fall(src_fall),
      .ctrl(gctl),
      .en(en_eff[g]),
      .stop_en(stop_en[g]),
      .drv(diff_out[g])
    );
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_pd_two_edges: assert property (
    $rose(pd_rec_q) |-> $past(src_fall) && !$past(s2_q.power_down_n)
      && $past(pd_cnt_q) == 2'h1)
    else $error("power-down recognised without two low samples");

  a_park_on_rise: assert property (
    $rose(seq_q == SEQ_PARKED) |-> $past(src_rise) && $past(pd_rec_q))
    else $error("parking not on a comp falling edge");

  a_park_drive: assert property (
    seq_q == SEQ_PARKED && !ctrl0_q[`B_PD_TRI] |-> diff_out[0].true_oe
      && diff_out[0].diff_out_true && !diff_out[0].comp_oe
      && diff_out[0].true_iref == IREF_2X)
    else $error("parked pair not held high at 2x");

  a_delay_len: assert property (
    seq_q == SEQ_DELAY && seq_d == SEQ_WAIT |-> cnt_q == DLY_LAST)
    else $error("power-up delay has wrong length");

  a_no_ref_float: assert property (
    seq_q == SEQ_WAIT && !s2_q.ref_valid |-> !diff_out[1].true_oe
      && !diff_out[1].comp_oe)
    else $error("pair driven without a reference clock");

  a_run_after_lock: assert property (
    $rose(seq_q == SEQ_RUN) |-> $past(s2_q.pll_locked)
      && $past(seq_q) == SEQ_WAIT)
    else $error("outputs enabled before lock");

  a_stop_debounce: assert property (
    $changed(stop_rec_q) |-> $past(src_fall)
      && $past(stop_cand_q) == $past(s2_q.output_stop_n))
    else $error("stop level changed without two equal samples");

  a_stop_hi_fast: assert property (
    diff_out[2].held && ctrl0_q[`B_STOP_TRI] && $rose(s2_q.output_stop_n)
      |-> ##[0:2] diff_out[2].true_oe && diff_out[2].diff_out_true)
    else $error("stopped true output not driven high in time");

  a_dis_float: assert property (
    seq_q == SEQ_RUN && !en_eff[3] && !$past(en_eff[3]) && src_fall
      |=> !diff_out[3].true_oe && !diff_out[3].comp_oe)
    else $error("disabled pair still driven");

  a_half_clean: assert property (
    $changed(half_q) |-> src && !$past(src))
    else $error("half-rate switch not at a common rising edge");

  a_bypass_or: assert property (
    ##1 pll_bypass == ($past(!ctrl0_q[`B_BYP])
      || $past(!s2_q.bypass_select_n)))
    else $error("bypass select wrong");

  c_stop_cycle: cover property (
    stop_rec_q && diff_out[0].held ##[1:200] !diff_out[0].held);
  c_pd_cycle: cover property (
    seq_q == SEQ_PARKED ##[1:400] seq_q == SEQ_RUN);
  c_half_mode: cover property ($rose(half_q));

endmodule

`default_nettype wire

//--- logic/diff_clock_pkg.sv
// types shared by the differential clock output control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package diff_clock_pkg;

  typedef enum logic [4:0] {
    SEQ_OFF    = 5'h01,
    SEQ_DELAY  = 5'h02,
    SEQ_WAIT   = 5'h04,
    SEQ_RUN    = 5'h08,
    SEQ_PARKED = 5'h10
  } seq_state_e;

  typedef enum logic [2:0] {
    GATE_OFF  = 3'h1,
    GATE_RUN  = 3'h2,
    GATE_HELD = 3'h4
  } gate_state_e;

  typedef enum logic [1:0] {
    IREF_NONE = 2'h0,
    IREF_1X   = 2'h1,
    IREF_2X   = 2'h2,
    IREF_6X   = 2'h3
  } iref_level_e;

  // drive of one output pair; an oe of 0 means the pin floats
  typedef struct packed {
    logic diff_out_true;
    logic true_oe;
    logic diff_out_comp;
    logic comp_oe;
    iref_level_e true_iref;
    logic held;
  } pair_drive_s;

  // controls common to every pair gate
  typedef struct packed {
    logic park;
    logic park_float;
    logic stop;
    logic stop_live;
    logic stop_tri;
  } gate_ctrl_s;

  // asynchronous pins, synchronised together
  typedef struct packed {
    logic power_down_n;
    logic output_stop_n;
    logic [3:0] oe_pin;
    logic bypass_select_n;
    logic bandwidth_select_n;
    logic supply_ok;
    logic ref_valid;
    logic ref_clock_in;
    logic pll_locked;
  } pins_s;

endpackage

`default_nettype wire

//--- logic/diff_pair_gate.sv
// glitch-free gate for one differential output pair
// assumes src edges are one-cycle pulses derived from src in core_clk
`default_nettype none

module diff_pair_gate
  import diff_clock_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // selected output clock
  input wire logic src,
  input wire logic src_rise,
  input wire logic src_fall,
  // controls
  input wire gate_ctrl_s ctrl,
  input wire logic en,
  input wire logic stop_en,
  // pair drive
  output pair_drive_s drv
);

  gate_state_e st_q, st_d;
  logic stop_me;

  // ----------------------------------------------------------------------
  // gate state
  // ----------------------------------------------------------------------
  always_comb begin
    stop_me = ctrl.stop & stop_en;
    st_d = st_q;
    unique case (st_q)
      GATE_OFF: begin
        // start only on a rising source edge, so the first high is whole
        if (src_rise && en && !stop_me && !ctrl.park) begin
          st_d = GATE_RUN;
        end
      end
      GATE_RUN: begin
        if (ctrl.park) begin
          st_d = GATE_OFF;
        end else if (src_rise && stop_me) begin
          st_d = GATE_HELD;
        end else if (src_fall && !en) begin
          st_d = GATE_OFF;
        end
      end
      GATE_HELD: begin
        if (ctrl.park || !en) begin
          st_d = GATE_OFF;
        end else if (src_rise && !stop_me) begin
          st_d = GATE_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= GATE_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  // combinational so a static drive-high lands within two core cycles
  always_comb begin
    drv = '0;
    if (ctrl.park) begin
      if (!ctrl.park_float) begin
        drv.diff_out_true = 1'b1;
        drv.true_oe = 1'b1;
        drv.true_iref = IREF_2X;
      end
    end else if (st_q == GATE_RUN) begin
      drv.diff_out_true = src;
      drv.diff_out_comp = ~src;
      drv.true_oe = 1'b1;
      drv.comp_oe = 1'b1;
      drv.true_iref = IREF_1X;
    end else if (st_q == GATE_HELD) begin
      drv.held = 1'b1;
      if (!ctrl.stop_tri) begin
        drv.diff_out_true = 1'b1;
        drv.true_oe = 1'b1;
        drv.true_iref = IREF_6X;
      end else if (ctrl.stop_live) begin
        drv.diff_out_true = 1'b1;
        drv.true_oe = 1'b1;
        drv.true_iref = IREF_1X;
      end
    end else if (en) begin
      drv.diff_out_true = 1'b1;
      drv.true_oe = 1'b1;
      drv.true_iref = IREF_1X;
    end
  end

endmodule

`default_nettype wire

//--- test/diff_clock_output_control_tb.sv
// ----------------------------------------------------------------------
// bench for the differential clock output control block
// ----------------------------------------------------------------------
// assumes the power management model drives reference, lock, pd and stop
`default_nettype none

module diff_clock_output_control_tb
  import diff_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  logic core_clk, rst_b, reg_wr, reg_rd, power_down_n, output_stop_n;
  logic bypass_select_n, bandwidth_select_n, supply_ok, ref_clock_valid;
  logic ref_clock_in, pll_locked, pll_enable, pll_bypass, pll_low_bw;
  logic clk_on, pd_req, stop_req, t;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
  logic [3:0] oe_pin;
  pair_drive_s diff_out [4];
  int err_count, total_checks, seed, n, k, i;
  int pb [4] = '{1, 2, 5, 6};

  diff_clock_output_control #(.DLY_CYC(DLY), .LOCK_CYC(400)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_down_n(power_down_n),
    .output_stop_n(output_stop_n), .oe_pin(oe_pin),
    .bypass_select_n(bypass_select_n),
    .bandwidth_select_n(bandwidth_select_n), .supply_ok(supply_ok),
    .ref_clock_valid(ref_clock_valid), .ref_clock_in(ref_clock_in),
    .pll_locked(pll_locked), .pll_enable(pll_enable),
    .pll_bypass(pll_bypass), .pll_low_bw(pll_low_bw),
    .diff_out(diff_out));

  power_mgr_model u_pm (
    .core_clk(core_clk), .clk_on(clk_on), .pd_req(pd_req),
    .stop_req(stop_req), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .ref_clock_in(ref_clock_in),
    .ref_clock_valid(ref_clock_valid), .power_down_n(power_down_n),
    .output_stop_n(output_stop_n));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // polls status until the masked value shows, bounded
  task automatic st_to(input logic [7:0] m, input logic [7:0] v);
    for (n = 0; n < 300; n++) begin
      rd(8'h06);
      if ((d & m) === v) break;
    end
    if (n >= 300) begin
      err_count++;
      wrap_up();
    end
    chk(d & m, v);
  endtask

  // drive of a pair; in float mode only the enables are meaningful
  function automatic logic [7:0] pk(pair_drive_s p, logic f);
    return 8'({p.diff_out_true, p.true_oe, p.comp_oe, p.true_iref})
      & (f ? 8'h0c : 8'h1f);
  endfunction

  function automatic logic [7:0] px(logic f, logic [1:0] ir);
    return f ? 8'h00 : 8'({3'b110, ir});
  endfunction

  initial begin
    seed = 77282;
    {reg_wr, reg_rd, supply_ok, clk_on, pd_req, stop_req, rst_b} = '0;
    {bypass_select_n, bandwidth_select_n, oe_pin} = 6'h3f;
    {reg_addr, reg_wdata, err_count, total_checks} = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'h00); chk(d, 8'h07);
    rd(8'h01);
    chk(d, 8'hff);
    rd(8'h02); chk(d, 8'h00);
    rd(8'h03); chk(d, 8'h00);
    rd(8'h04);
    chk(d, 8'h5a);
    rd(8'h06); chk(d & 8'hf8, 8'h08);
    r = 8'($random(seed));
    wr(8'h00, r); rd(8'h00); chk(d, r & 8'hc7);
    wr(8'h02, 8'hff); rd(8'h02); chk(d, 8'h66);
    wr(8'h00, 8'h07);
    wr(8'h02, 8'h00);
    $display("registers done");
    supply_ok <= 1'b1;
    st_to(8'hf8, 8'h10);
    repeat (DLY - 4) @(posedge core_clk);
    rd(8'h06); chk(d & 8'hf8, 8'h10);
    st_to(8'hf8, 8'h20); chk(8'(n <= 4), 8'h01);
    repeat (30) @(posedge core_clk);
    rd(8'h06); chk(d & 8'hf8, 8'h20);
    chk(8'(diff_out[0].true_oe), 8'h00);
    clk_on <= 1'b1;
    st_to(8'hfc, 8'h40); chk(8'(pll_locked), 8'h01);
    $display("power-up done");
    for (k = 0; k < 16; k++) begin
      @(posedge core_clk);
      {bandwidth_select_n, bypass_select_n} <= 2'(k);
      wr(8'h00, {5'h00, k[3], k[2], 1'b1});
      repeat (4) @(posedge core_clk);
      #1 chk(8'(pll_bypass), 8'(!(k[0] & k[2])));
      chk(8'(pll_low_bw), 8'(!(k[1] & k[3])));
    end
    @(posedge core_clk);
    {bypass_select_n, bandwidth_select_n} <= 2'b11;
    wr(8'h00, 8'h07);
    st_to(8'hf8, 8'h40);
    $display("pin combine done");
    for (k = 0; k < 6; k++) begin
      r = (k == 0) ? 8'h00 : (k == 5) ? 8'hff : 8'($random(seed));
      @(posedge core_clk);
      oe_pin <= (k == 5) ? 4'hf : 4'($random(seed));
      wr(8'h01, r);
      // eight periods of eight cycles, pin sync included
      repeat (64) @(posedge core_clk);
      #1;
      for (i = 0; i < 4; i++) begin
        chk(8'(diff_out[i].true_oe), 8'(oe_pin[i] & r[pb[i]]));
      end
    end
    @(posedge core_clk);
    oe_pin <= 4'he;
    repeat (64) @(posedge core_clk);
    oe_pin <= 4'hf;
    repeat (3) @(posedge core_clk);
    #1 chk(8'({diff_out[0].diff_out_true, diff_out[0].true_oe}), 8'h03);
    $display("enables done");
    wr(8'h02, 8'h22);
    for (k = 0; k < 2; k++) begin
      t = k[0];
      wr(8'h00, {1'b0, t, 6'h07});
      @(posedge core_clk);
      stop_req <= 1'b1;
      st_to(8'h01, 8'h01);
      repeat (24) @(posedge core_clk);
      #1 chk(pk(diff_out[0], t), px(t, 2'b11));
      chk(8'({diff_out[1].held, diff_out[1].comp_oe}), 8'h01);
      r = 8'({diff_out[1].diff_out_true, diff_out[1].diff_out_comp});
      chk(8'(r == 8'h01 || r == 8'h02), 8'h01);
      stop_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      if (t) begin
        #1 chk(8'({diff_out[0].diff_out_true, diff_out[0].true_oe}), 8'h03);
      end
      repeat (56) @(posedge core_clk);
      #1 chk(8'({diff_out[0].held, diff_out[0].comp_oe}), 8'h01);
    end
    wr(8'h02, 8'h00);
    $display("stop done");
    for (k = 0; k < 2; k++) begin
      t = k[0];
      wr(8'h00, {t, 7'h07});
      @(posedge core_clk);
      pd_req <= 1'b1;
      st_to(8'hfa, 8'h82);
      chk(pk(diff_out[0], t), px(t, 2'b10));
      chk(8'(pll_enable), 8'h00);
      @(posedge core_clk);
      pd_req <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1 chk(8'({diff_out[0].diff_out_true, diff_out[0].true_oe}), 8'h03);
      st_to(8'hfe, 8'h40);
      chk(8'(pll_enable), 8'h01);
    end
    $display("power-down done");
    for (k = 0; k < 2; k++) begin
      wr(8'h00, {7'h03, k[0]});
      repeat (80) @(posedge core_clk);
      #1 t = diff_out[0].diff_out_true;
      n = 0;
      repeat (64) begin
        @(posedge core_clk);
        #1 if (diff_out[0].diff_out_true && !t) n++;
        t = diff_out[0].diff_out_true;
      end
      chk(8'(n), k[0] ? 8'h08 : 8'h04);
    end
    $display("half rate done");
    wrap_up();
  end
endmodule

`default_nettype wire

//--- test/power_mgr_model.sv
// ----------------------------------------------------------------------
// far-side power management model
// ----------------------------------------------------------------------
// makes the reference clock, the pll lock flag and the pd and stop pins
// assumes the bench asks for pin changes and shares core_clk
`default_nettype none

module power_mgr_model (
  // clock
  input wire logic core_clk,
  // requests of the bench
  input wire logic clk_on,
  input wire logic pd_req,
  input wire logic stop_req,
  // pll
  input wire logic pll_enable,
  output logic pll_locked,
  // pins
  output logic ref_clock_in,
  output logic ref_clock_valid,
  output logic power_down_n,
  output logic output_stop_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic [3:0] lk;

  initial begin
    {ph, lk, ref_clock_in, ref_clock_valid, pll_locked} = '0;
    {power_down_n, output_stop_n} = 2'b11;
  end

  always @(posedge core_clk) begin
    power_down_n <= !pd_req;
    output_stop_n <= !stop_req;
    // the clock may only be taken away under power-down
    ref_clock_valid <= clk_on | (ref_clock_valid & power_down_n);
    ph <= ph + 2'h1;
    // clock stands still while it is absent
    if (ref_clock_valid && ph == 2'h3) begin
      ref_clock_in <= !ref_clock_in;
    end
    // lock is lost whenever the pll is off, so every start relocks
    if (!(pll_enable && ref_clock_valid)) begin
      lk <= 4'h0;
    end else if (lk != 4'hf) begin
      lk <= lk + 4'h1;
    end
    pll_locked <= (lk == 4'hf);
  end
endmodule

`default_nettype wire
